// ### video_source_regs_pkg.sv
// Register map, field layout and carrier types of the video source
// stream and transmit PHY configuration bank.
// Assumes one host clock drives both the register port and the logic.
package video_source_regs_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_LANES = 4;
  localparam int NUM_STREAMS = 4;

  // ------------------------------------------------------------------
  // Register index, in the order of the offset and mask tables
  // ------------------------------------------------------------------
  typedef enum int {
    IX_HTOTAL, IX_VTOTAL, IX_POLARITY, IX_HSWIDTH, IX_VSWIDTH,
    IX_HACTIVE, IX_VACTIVE, IX_HSTART, IX_VSTART, IX_ATTR_A, IX_ATTR_B,
    IX_M, IX_UNIT_LEN, IX_N, IX_PIX_LANES, IX_WORD_COUNT, IX_INTERLACE,
    IX_BYTES_INT, IX_BYTES_FRAC, IX_LINE_WAIT, IX_TS0, IX_TS1, IX_TS2,
    IX_TS3, IX_PHY, IX_SWING0, IX_SWING1, IX_SWING2, IX_SWING3,
    IX_PATTERN, IX_RATE, IX_COUNT
  } reg_index_t;

  localparam int NUM_REGS = IX_COUNT;

  localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
    12'h180, 12'h184, 12'h188, 12'h18C, 12'h190, 12'h194, 12'h198,
    12'h19C, 12'h1A0, 12'h1A4, 12'h1A8, 12'h1AC, 12'h1B0, 12'h1B4,
    12'h1B8, 12'h1BC, 12'h1C0, 12'h1C4, 12'h1C8, 12'h1CC, 12'h1D0,
    12'h1D4, 12'h1D8, 12'h1DC, 12'h200, 12'h220, 12'h224, 12'h228,
    12'h22C, 12'h230, 12'h234
  };

  // Writable bits; everything outside a mask stores and reads as zero
  localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
    32'h0000FFFF, 32'h0000FFFF, 32'h00000003, 32'h00007FFF,
    32'h00007FFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
    32'h0000FFFF, 32'h000000FF, 32'h00000007, 32'h00FFFFFF,
    32'h0000007E, 32'h00FFFFFF, 32'h00000007, 32'hFFFFFFFF,
    32'h00000001, 32'h0000007F, 32'h000003FF, 32'h000000FF,
    32'h00FF03FF, 32'h00FF03FF, 32'h00FF03FF, 32'h00FF03FF,
    32'h081FFB03, 32'h0000000F, 32'h0000000F, 32'h0000000F,
    32'h0000000F, 32'h0001FFFF, 32'h00000007
  };

  localparam logic [DATA_W-1:0] UNIT_LEN_RESET = 32'h00000040;
  localparam logic [DATA_W-1:0] LINE_WAIT_RESET = 32'h00000020;
  localparam logic [DATA_W-1:0] PHY_RESET = 32'h00100003;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int POL_HSYNC_BIT = 0;
  localparam int POL_VSYNC_BIT = 1;
  localparam int ATTR_A_SYNC_CLK_BIT = 0;
  localparam int ATTR_A_FORMAT_LSB = 1;
  localparam int ATTR_A_RANGE_BIT = 3;
  localparam int ATTR_A_COLORIMETRY_BIT = 4;
  localparam int ATTR_A_DEPTH_LSB = 5;
  localparam int ATTR_B_VT_EVEN_BIT = 0;
  localparam int ATTR_B_STEREO_LSB = 1;
  localparam int TIMESLOT_FRACTION_LSB = 0;
  localparam int TIMESLOT_INTEGER_LSB = 16;
  localparam int PHY_CORE_RESET_BIT = 0;
  localparam int PHY_TX_RESET_BIT = 1;
  localparam int PHY_ANALOG_RESET_BIT = 8;
  localparam int PHY_CODING_RESET_BIT = 9;
  localparam int PHY_INVERT_ALL_LSB = 11;
  localparam int PHY_LOOPBACK_LSB = 13;
  localparam int PHY_INVERT_LANE_LSB = 16;
  localparam int PHY_LINE_CODE_BIT = 20;
  localparam int PHY_INHIBIT_BIT = 27;
  localparam int PATTERN_PRBS_BIT = 0;
  localparam int PATTERN_SPARE_LSB = 1;

  // ------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] RATE_CODE_5G40 = 3'h5;
  localparam logic [2:0] RATE_CODE_2G70 = 3'h3;
  localparam logic [2:0] RATE_CODE_1G62 = 3'h1;
  localparam logic [2:0] PIX_CODE_SINGLE = 3'h1;
  localparam logic [2:0] PIX_CODE_DUAL = 3'h2;
  localparam logic [2:0] PIX_CODE_QUAD = 3'h4;

  typedef enum logic [1:0] {
    RATE_NONE, RATE_1G62, RATE_2G70, RATE_5G40
  } link_rate_t;

  typedef enum logic [1:0] {
    PIX_INVALID, PIX_SINGLE, PIX_DUAL, PIX_QUAD
  } pixel_mode_t;

  typedef struct packed {
    logic [15:0] h_total;
    logic [15:0] v_total;
    logic vsync_pol;
    logic hsync_pol;
    logic [14:0] hsync_width;
    logic [14:0] vsync_width;
    logic [15:0] h_active;
    logic [15:0] v_active;
    logic [15:0] h_start;
    logic [15:0] v_start;
    logic [7:0] attr_a;
    logic [7:0] attr_b;
    logic [23:0] m_value;
    logic [23:0] n_value;
    logic [6:0] transfer_unit_length;
    pixel_mode_t pixel_mode;
    logic [31:0] words_per_lane;
    logic attr_interlaced;
    logic vertical_blank_identifier_interlaced;
    logic [6:0] unit_bytes_integer;
    logic [9:0] unit_bytes_fraction;
  } stream_cfg_t;

  typedef struct packed {
    logic [7:0] timeslot_integer;
    logic [9:0] timeslot_fraction;
  } timeslot_t;

  typedef struct packed {
    logic phy_reset;
    logic transceiver_tx_reset;
    logic tx_analog_attach_reset;
    logic tx_coding_sublayer_reset;
    logic [1:0] tx_lane_inversion_all;
    logic [2:0] tx_loopback_select;
    logic [NUM_LANES-1:0] tx_lane_inversion;
    logic line_code_enable;
    logic tx_output_inhibit;
    logic [NUM_LANES-1:0][3:0] swing;
    logic prbs7_enable;
    logic [15:0] coding_sublayer_spare_input;
    link_rate_t link_rate;
  } phy_cfg_t;

endpackage

// ### prbs7_source.sv
// PRBS7 pattern source, WIDTH bits per clock, oldest bit in bit 0.
// Assumes the serializer consumes WIDTH bits on every clock.
`timescale 1ns/100ps
module prbs7_source #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic enable_i,
  output logic [WIDTH-1:0] pattern_o
);

  localparam logic [6:0] SEED = 7'h7F;

  typedef struct packed {
    logic [6:0] lfsr;
    logic [WIDTH-1:0] bits;
  } prbs_state_t;

  prbs_state_t state;
  prbs_state_t next_state;

  // Polynomial x^7 + x^6 + 1; restarts from the seed when disabled
  always_comb begin
    logic [6:0] shift;
    shift = state.lfsr;
    next_state = state;
    if (enable_i) begin
      for (int b = 0; b < WIDTH; b++) begin
        next_state.bits[b] = shift[6];
        shift = {shift[5:0], shift[6] ^ shift[5]};
      end
      next_state.lfsr = shift;
    end else begin
      next_state.lfsr = SEED;
      next_state.bits = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= '{lfsr: SEED, bits: '0};
    end else begin
      state <= next_state;
    end
  end

  assign pattern_o = state.bits;

endmodule

// ### video_source_stream_phy_regs.sv
// Stream attribute and transmit PHY configuration bank of a video
// link source, with the line start wait timer and the PRBS7 source.
// Assumes the host register port is synchronous to ref_clk_i.
`timescale 1ns/100ps
module video_source_stream_phy_regs
  import video_source_regs_pkg::*;
#(
  parameter int PATTERN_WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic [DATA_W-1:0] host_wdata_i,
  output logic [DATA_W-1:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic [23:0] measured_m_i,
  input wire logic line_start_i,
  output logic line_wait_o,
  output stream_cfg_t stream_cfg_o,
  output timeslot_t [NUM_STREAMS-1:0] timeslots_o,
  output phy_cfg_t phy_cfg_o,
  output logic [PATTERN_WIDTH-1:0] prbs_pattern_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic [23:0] m_out;
    link_rate_t rate;
    pixel_mode_t pix;
    logic [7:0] wait_count;
    logic wait_busy;
  } state_t;

  state_t state;
  state_t next_state;

  function automatic logic [NUM_REGS-1:0][DATA_W-1:0] regs_reset();
    logic [NUM_REGS-1:0][DATA_W-1:0] r;
    r = '0;
    r[IX_UNIT_LEN] = UNIT_LEN_RESET;
    r[IX_LINE_WAIT] = LINE_WAIT_RESET;
    r[IX_PHY] = PHY_RESET;
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] rd_word;
    logic [7:0] wait_len;
    logic [2:0] rate_code;
    logic [2:0] pix_code;
    rd_word = '0;
    wait_len = '0;
    rate_code = '0;
    pix_code = '0;
    next_state = state;

    // Host writes; masking keeps reserved bits and unit bit 0 at zero
    for (int i = 0; i < NUM_REGS; i++) begin
      if (host_wr_i && host_addr_i == REG_OFFSET[i]) begin
        next_state.regs[i] = host_wdata_i & REG_MASK[i];
      end
    end

    // Reads answer one clock later; unmapped offsets read zero
    for (int i = 0; i < NUM_REGS; i++) begin
      if (host_addr_i == REG_OFFSET[i]) begin
        rd_word = state.regs[i];
      end
    end
    next_state.rd_valid = host_rd_i;
    next_state.rd_data = host_rd_i ? rd_word : '0;

    // Async clocking: computed M goes to the stream, never to readback
    if (state.regs[IX_ATTR_A][ATTR_A_SYNC_CLK_BIT]) begin
      next_state.m_out = state.regs[IX_M][23:0];
    end else begin
      next_state.m_out = measured_m_i;
    end

    // Unlisted codes leave the PLL unconfigured rather than guessing
    rate_code = state.regs[IX_RATE][2:0];
    case (rate_code)
      RATE_CODE_5G40: next_state.rate = RATE_5G40;
      RATE_CODE_2G70: next_state.rate = RATE_2G70;
      RATE_CODE_1G62: next_state.rate = RATE_1G62;
      default: next_state.rate = RATE_NONE;
    endcase

    pix_code = state.regs[IX_PIX_LANES][2:0];
    case (pix_code)
      PIX_CODE_SINGLE: next_state.pix = PIX_SINGLE;
      PIX_CODE_DUAL: next_state.pix = PIX_DUAL;
      PIX_CODE_QUAD: next_state.pix = PIX_QUAD;
      default: next_state.pix = PIX_INVALID;
    endcase

    // Line start wait: busy for exactly the programmed number of cycles;
    // a new line start restarts the count, zero means no wait at all
    wait_len = state.regs[IX_LINE_WAIT][7:0];
    if (line_start_i) begin
      next_state.wait_busy = (wait_len != 8'h00);
      next_state.wait_count = wait_len - 8'h01;
    end else if (state.wait_busy) begin
      if (state.wait_count == 8'h00) begin
        next_state.wait_busy = 1'b0;
      end else begin
        next_state.wait_count = state.wait_count - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state.regs <= regs_reset();
      state.rd_data <= '0;
      state.rd_valid <= 1'b0;
      state.m_out <= '0;
      state.rate <= RATE_NONE;
      state.pix <= PIX_INVALID;
      state.wait_count <= '0;
      state.wait_busy <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, wired from state bits
  // ------------------------------------------------------------------
  assign host_rdata_o = state.rd_data;
  assign host_rvalid_o = state.rd_valid;
  assign line_wait_o = state.wait_busy;

  always_comb begin
    stream_cfg_o.h_total = state.regs[IX_HTOTAL][15:0];
    stream_cfg_o.v_total = state.regs[IX_VTOTAL][15:0];
    stream_cfg_o.vsync_pol = state.regs[IX_POLARITY][POL_VSYNC_BIT];
    stream_cfg_o.hsync_pol = state.regs[IX_POLARITY][POL_HSYNC_BIT];
    stream_cfg_o.hsync_width = state.regs[IX_HSWIDTH][14:0];
    stream_cfg_o.vsync_width = state.regs[IX_VSWIDTH][14:0];
    stream_cfg_o.h_active = state.regs[IX_HACTIVE][15:0];
    stream_cfg_o.v_active = state.regs[IX_VACTIVE][15:0];
    stream_cfg_o.h_start = state.regs[IX_HSTART][15:0];
    stream_cfg_o.v_start = state.regs[IX_VSTART][15:0];
    // Field layout of attribute byte A, bit 0 also steers M selection
    stream_cfg_o.attr_a = state.regs[IX_ATTR_A][7:0];
    // Bits 7:3 of attribute byte B are held at zero by the write mask
    stream_cfg_o.attr_b = state.regs[IX_ATTR_B][7:0];
    stream_cfg_o.m_value = state.m_out;
    stream_cfg_o.n_value = state.regs[IX_N][23:0];
    stream_cfg_o.transfer_unit_length =
      state.regs[IX_UNIT_LEN][6:0];
    stream_cfg_o.pixel_mode = state.pix;
    stream_cfg_o.words_per_lane = state.regs[IX_WORD_COUNT];
    stream_cfg_o.attr_interlaced = state.regs[IX_INTERLACE][0];
    stream_cfg_o.vertical_blank_identifier_interlaced =
      state.regs[IX_INTERLACE][0];
    stream_cfg_o.unit_bytes_integer = state.regs[IX_BYTES_INT][6:0];
    stream_cfg_o.unit_bytes_fraction = state.regs[IX_BYTES_FRAC][9:0];
  end

  always_comb begin
    for (int s = 0; s < NUM_STREAMS; s++) begin
      timeslots_o[s].timeslot_integer =
        state.regs[IX_TS0 + s][TIMESLOT_INTEGER_LSB +: 8];
      timeslots_o[s].timeslot_fraction =
        state.regs[IX_TS0 + s][TIMESLOT_FRACTION_LSB +: 10];
    end
  end

  always_comb begin
    phy_cfg_o.phy_reset = state.regs[IX_PHY][PHY_CORE_RESET_BIT];
    phy_cfg_o.transceiver_tx_reset =
      state.regs[IX_PHY][PHY_TX_RESET_BIT];
    phy_cfg_o.tx_analog_attach_reset =
      state.regs[IX_PHY][PHY_ANALOG_RESET_BIT];
    phy_cfg_o.tx_coding_sublayer_reset =
      state.regs[IX_PHY][PHY_CODING_RESET_BIT];
    phy_cfg_o.tx_lane_inversion_all =
      state.regs[IX_PHY][PHY_INVERT_ALL_LSB +: 2];
    phy_cfg_o.tx_loopback_select =
      state.regs[IX_PHY][PHY_LOOPBACK_LSB +: 3];
    phy_cfg_o.tx_lane_inversion =
      state.regs[IX_PHY][PHY_INVERT_LANE_LSB +: NUM_LANES];
    phy_cfg_o.line_code_enable =
      state.regs[IX_PHY][PHY_LINE_CODE_BIT];
    phy_cfg_o.tx_output_inhibit =
      state.regs[IX_PHY][PHY_INHIBIT_BIT];
    for (int l = 0; l < NUM_LANES; l++) begin
      phy_cfg_o.swing[l] = state.regs[IX_SWING0 + l][3:0];
    end
    phy_cfg_o.prbs7_enable =
      state.regs[IX_PATTERN][PATTERN_PRBS_BIT];
    phy_cfg_o.coding_sublayer_spare_input =
      state.regs[IX_PATTERN][PATTERN_SPARE_LSB +: 16];
    phy_cfg_o.link_rate = state.rate;
  end

  // ------------------------------------------------------------------
  // Test pattern
  // ------------------------------------------------------------------
  prbs7_source #(
    .WIDTH(PATTERN_WIDTH)
  ) u_prbs7 (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .enable_i(state.regs[IX_PATTERN][PATTERN_PRBS_BIT]),
    .pattern_o(prbs_pattern_o)
  );

endmodule

// ### video_source_stream_phy_regs_chk.sv
// Concurrent checks on the ports of the video source register bank.
// Assumes it is bound to the bank and sees nothing but its ports.
`timescale 1ns/100ps
module video_source_stream_phy_regs_chk
  import video_source_regs_pkg::*;
#(
  parameter int PATTERN_WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic [DATA_W-1:0] host_wdata_i,
  input wire logic [DATA_W-1:0] host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic [23:0] measured_m_i,
  input wire logic line_start_i,
  input wire logic line_wait_o,
  input wire stream_cfg_t stream_cfg_o,
  input wire phy_cfg_t phy_cfg_o,
  input wire logic [PATTERN_WIDTH-1:0] prbs_pattern_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  chk_read_answered: assert property (host_rd_i |=> host_rvalid_o)
    else $error("read not answered one cycle later");
  chk_no_stray_answer: assert property (host_rvalid_o |->
    $past(host_rd_i) && !$past(srst_i))
    else $error("read answer without a request");
  chk_idle_rdata_zero: assert property (!host_rvalid_o |->
    host_rdata_o == '0)
    else $error("read data not zero while idle");
  chk_unit_len_even: assert property (
    host_wr_i && host_addr_i == 12'h1B0 |=> stream_cfg_o.transfer_unit_length
    == {$past(host_wdata_i[6:1]), 1'b0})
    else $error("unit length write not stored with bit 0 clear");
  chk_wait_cause: assert property ($rose(line_wait_o) |->
    $past(line_start_i))
    else $error("line wait began without a line start");
  chk_reset_values: assert property ($past(srst_i) |->
    phy_cfg_o.phy_reset && phy_cfg_o.transceiver_tx_reset &&
    phy_cfg_o.line_code_enable && stream_cfg_o.transfer_unit_length == 7'h40)
    else $error("configuration not at reset value");
  chk_rate_fast: assert property (
    host_wr_i && host_addr_i == REG_OFFSET[IX_RATE] &&
    host_wdata_i[2:0] == RATE_CODE_5G40 |=> ##1
    phy_cfg_o.link_rate == RATE_5G40)
    else $error("fastest rate code not decoded");
  chk_m_async: assert property (!$past(srst_i) &&
    !$past(stream_cfg_o.attr_a[0]) && !stream_cfg_o.attr_a[0] |->
    stream_cfg_o.m_value == $past(measured_m_i))
    else $error("measured M not used in asynchronous clocking");
  chk_interlace_pair: assert property (
    host_wr_i && host_addr_i == REG_OFFSET[IX_INTERLACE] |=>
    stream_cfg_o.attr_interlaced == $past(host_wdata_i[0]) &&
    stream_cfg_o.vertical_blank_identifier_interlaced ==
    $past(host_wdata_i[0]))
    else $error("interlace flags not taken from the write");
  chk_pattern_idle: assert property (
    !phy_cfg_o.prbs7_enable [*2] |-> prbs_pattern_o == '0)
    else $error("pattern active while disabled");
endmodule

// ### video_lane_sink_model.sv
// Lane side model that checks the PRBS7 test pattern as a sink would.
// Assumes one pattern bit per clock, starting from the all-ones seed.
`timescale 1ns/100ps
module video_lane_sink_model (
  input wire logic ref_clk_i,
  input wire logic enable_i,
  input wire logic pattern_i,
  output logic [15:0] bits_seen_o,
  output logic [15:0] bit_errors_o
);
  logic [6:0] ref_lfsr;
  logic enabled_seen;

  initial begin
    ref_lfsr = 7'h7F;
    enabled_seen = 1'b0;
    bits_seen_o = 16'h0000;
    bit_errors_o = 16'h0000;
  end

  // Pattern trails the enable by one cycle, so the check does too
  always @(posedge ref_clk_i) begin
    enabled_seen <= enable_i;
    // Unknown enable before the first reset must not count as enabled
    if (enabled_seen !== 1'b1) begin
      ref_lfsr <= 7'h7F;
    end else begin
      ref_lfsr <= {ref_lfsr[5:0], ref_lfsr[6] ^ ref_lfsr[5]};
      bits_seen_o <= bits_seen_o + 16'h0001;
      if (pattern_i !== ref_lfsr[6]) begin
        bit_errors_o <= bit_errors_o + 16'h0001;
      end
    end
  end
endmodule

// ### video_source_stream_phy_regs_tb_top.sv
// Self-checking bench for the video source register bank.
// Assumes one 125 MHz host clock and the register map of the package.
`timescale 1ns/100ps
module video_source_stream_phy_regs_tb_top
  import video_source_regs_pkg::*;
;
  logic ref_clk_i;
  logic srst_i = 1'b1;
  logic host_wr_i = 1'b0;
  logic host_rd_i = 1'b0;
  logic [ADDR_W-1:0] host_addr_i = 12'h000;
  logic [DATA_W-1:0] host_wdata_i = 32'h00000000;
  logic [DATA_W-1:0] host_rdata_o;
  logic host_rvalid_o;
  logic [23:0] measured_m_i = 24'hABCDEF;
  logic line_start_i = 1'b0;
  logic line_wait_o;
  stream_cfg_t stream_cfg_o;
  timeslot_t [NUM_STREAMS-1:0] timeslots_o;
  phy_cfg_t phy_cfg_o;
  logic [0:0] prbs_pattern_o;
  logic [15:0] bits_seen;
  logic [15:0] bit_errors;
  int errors = 0;
  int tests_run = 0;

  video_source_stream_phy_regs i_video_source_stream_phy_regs (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .measured_m_i(measured_m_i),
    .line_start_i(line_start_i), .line_wait_o(line_wait_o),
    .stream_cfg_o(stream_cfg_o), .timeslots_o(timeslots_o),
    .phy_cfg_o(phy_cfg_o), .prbs_pattern_o(prbs_pattern_o)
  );

  video_lane_sink_model i_video_lane_sink_model (
    .ref_clk_i(ref_clk_i), .enable_i(phy_cfg_o.prbs7_enable),
    .pattern_i(prbs_pattern_o[0]), .bits_seen_o(bits_seen),
    .bit_errors_o(bit_errors)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------------
  // Host port tasks; write strobes stay up so writes run back to back
  // ------------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    host_wr_i <= 1'b0;
    host_rd_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_rd_i <= 1'b0;
    host_wr_i <= 1'b1;
    host_addr_i <= a;
    host_wdata_i <= d;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    host_wr_i <= 1'b0;
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge ref_clk_i);
    host_rd_i <= 1'b0;
    #1;
    cmp("read valid", 32'h1, host_rvalid_o);
    cmp("read data", exp, host_rdata_o);
    @(posedge ref_clk_i);
  endtask

  task automatic do_reset;
    srst_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
  endtask

  // Counts the wait length between clock edges, where it is settled
  task automatic pulse_wait(input int n);
    int cnt;
    cnt = 0;
    tick(2);
    line_start_i <= 1'b1;
    @(posedge ref_clk_i);
    line_start_i <= 1'b0;
    @(negedge ref_clk_i);
    while (line_wait_o === 1'b1 && cnt < 300) begin
      cnt++;
      @(negedge ref_clk_i);
    end
    if (cnt >= 300) begin
      errors++;
      end_sim;
    end
    cmp("line wait", n, cnt);
    @(posedge ref_clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    end_sim;
  end

  initial begin
    logic [2:0] pcode [5];
    pixel_mode_t pexp [5];
    logic [2:0] rcode [5];
    link_rate_t rexp [5];
    logic [11:0] bad [4];
    logic [31:0] exp;
    pcode = '{PIX_CODE_SINGLE, PIX_CODE_DUAL, PIX_CODE_QUAD, 3'h3, 3'h0};
    pexp = '{PIX_SINGLE, PIX_DUAL, PIX_QUAD, PIX_INVALID, PIX_INVALID};
    rcode = '{RATE_CODE_5G40, RATE_CODE_2G70, RATE_CODE_1G62, 3'h2, 3'h7};
    rexp = '{RATE_5G40, RATE_2G70, RATE_1G62, RATE_NONE, RATE_NONE};
    bad = '{12'h1E0, 12'h1FC, 12'h181, 12'h238};
    do_reset;
    for (int i = 0; i < NUM_REGS; i++) begin
      exp = (i == IX_UNIT_LEN) ? UNIT_LEN_RESET :
            (i == IX_LINE_WAIT) ? LINE_WAIT_RESET :
            (i == IX_PHY) ? PHY_RESET : 32'h00000000;
      rd(REG_OFFSET[i], exp);
    end
    pulse_wait(32);
    for (int i = 0; i < NUM_REGS; i++) begin
      wr(REG_OFFSET[i], 32'hFFFFFFFF);
    end
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(REG_OFFSET[i], REG_MASK[i]);
    end
    cmp("hsync width", 32'h7FFF, stream_cfg_o.hsync_width);
    cmp("attr b", 32'h07, stream_cfg_o.attr_b);
    cmp("unit length", 32'h7E, stream_cfg_o.transfer_unit_length);
    cmp("v total", 32'hFFFF, stream_cfg_o.v_total);
    cmp("v start", 32'hFFFF, stream_cfg_o.v_start);
    for (int j = 0; j < 4; j++) begin
      wr(bad[j], 32'hFFFFFFFF);
      rd(bad[j], 32'h00000000);
    end
    rd(12'h180, 32'h0000FFFF);
    wr(12'h1CC, 32'h00000003);
    pulse_wait(3);
    wr(12'h1CC, 32'h00000000);
    pulse_wait(0);
    wr(12'h188, 32'h00000002);
    tick(2);
    cmp("polarity", 32'h2,
        {stream_cfg_o.vsync_pol, stream_cfg_o.hsync_pol});
    for (int k = 0; k < 5; k++) begin
      wr(12'h1B8, {29'h0, pcode[k]});
      wr(12'h234, {29'h0, rcode[k]});
      tick(2);
      cmp("pixel mode", pexp[k], stream_cfg_o.pixel_mode);
      cmp("link rate", rexp[k], phy_cfg_o.link_rate);
    end
    for (int l = 0; l < 4; l++) begin
      wr(12'(12'h220 + 4 * l), 32'(l + 6));
      wr(12'(12'h1D0 + 4 * l),
         {8'h00, 8'(8'hA0 + l), 6'h3F, 10'(10'h3E7 - l)});
    end
    tick(2);
    for (int l = 0; l < 4; l++) begin
      cmp("swing", 32'(l + 6), phy_cfg_o.swing[l]);
      cmp("timeslots", {8'(8'hA0 + l), 10'(10'h3E7 - l)},
          timeslots_o[l]);
    end
    wr(12'h1C0, 32'h00000001);
    tick(2);
    cmp("interlace", 32'h3, {stream_cfg_o.attr_interlaced,
        stream_cfg_o.vertical_blank_identifier_interlaced});
    wr(12'h1C0, 32'hFFFFFFFE);
    tick(2);
    cmp("interlace", 32'h0, {stream_cfg_o.attr_interlaced,
        stream_cfg_o.vertical_blank_identifier_interlaced});
    measured_m_i <= 24'h13579B;
    wr(12'h1AC, 32'h00123456);
    wr(12'h1A4, 32'h000000B5);
    tick(3);
    cmp("m value", 32'h123456, stream_cfg_o.m_value);
    cmp("attr a", 32'hB5, stream_cfg_o.attr_a);
    wr(12'h1A4, 32'h000000B4);
    tick(3);
    cmp("m value", 32'h13579B, stream_cfg_o.m_value);
    rd(12'h1AC, 32'h00123456);
    // Software setup: 1920 pixels of 24 bits, four lanes, ratio 0.6
    exp = (32'h780 * 32'h18 + 32'hF) / 32'h10;
    exp = (exp + 32'h3) / 32'h4 * 32'h4 - 32'h4;
    wr(12'h194, 32'h00000780);
    wr(12'h1BC, exp);
    wr(12'h1C4, 32'h40 * 32'h6 / 32'hA);
    wr(12'h1C8, 32'h40 * 32'h6 * 32'h400 / 32'hA % 32'h400);
    wr(12'h1CC, 32'h40 - 32'h40 * 32'h6 / 32'hA);
    wr(12'h1B4, 32'h00654321);
    tick(2);
    cmp("h active", 32'h780, stream_cfg_o.h_active);
    cmp("words per lane", 32'hB3C, stream_cfg_o.words_per_lane);
    cmp("min bytes", 32'h26, stream_cfg_o.unit_bytes_integer);
    cmp("frac bytes", 32'h199, stream_cfg_o.unit_bytes_fraction);
    cmp("n value", 32'h654321, stream_cfg_o.n_value);
    pulse_wait(26);
    wr(12'h200, 32'h0800A300);
    tick(2);
    cmp("phy controls", {2'b00, 2'b11, 3'h5, 1'b0, 1'b1},
        {phy_cfg_o.phy_reset, phy_cfg_o.transceiver_tx_reset,
         phy_cfg_o.tx_analog_attach_reset,
         phy_cfg_o.tx_coding_sublayer_reset, phy_cfg_o.tx_loopback_select,
         phy_cfg_o.line_code_enable,
         phy_cfg_o.tx_output_inhibit});
    wr(12'h230, 32'h00000000);
    wr(12'h230, 32'h00000001);
    tick(60);
    wr(12'h230, 32'h00000000);
    tick(4);
    cmp("prbs errors", 32'h0, bit_errors);
    cmp("prbs checked", 32'h1, bits_seen > 16'd50);
    cmp("pattern idle", 32'h0, prbs_pattern_o);
    tick(1);
    do_reset;
    rd(12'h1B0, UNIT_LEN_RESET);
    rd(12'h200, PHY_RESET);
    end_sim;
  end
endmodule

bind video_source_stream_phy_regs video_source_stream_phy_regs_chk #(
  .PATTERN_WIDTH(PATTERN_WIDTH)
) i_video_source_stream_phy_regs_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
  .host_rvalid_o(host_rvalid_o), .measured_m_i(measured_m_i),
  .line_start_i(line_start_i), .line_wait_o(line_wait_o),
  .stream_cfg_o(stream_cfg_o), .phy_cfg_o(phy_cfg_o),
  .prbs_pattern_o(prbs_pattern_o)
);
